// File: rtl/cmf_message_filter.sv
// Notes on behaviour
// - accepted frame stores id, format, rtr, length, data
// - extended flag records received identifier width
// - multiple matches go to lowest object number
// - invalid objects neither send nor receive
// - invalidated mid-send still reports success, keeps request
// - mask_enable gates all three mask fields
// - masked remote on transmit object refreshes header
// - unmasked remote without answer enable is dropped
// - standard objects use identifier bits 28 to 18
// - mask bit one means identifier bit compared
// - extended flag picks 11 or 29 bit format
// - ext mask compares format, else frame decides
// - receive object sends remote or takes data
// - transmit object sends data, answers remotes
// - way mask zero excludes direction; keep one
// - buffer end marks fifo tail or standalone
// - fresh flag shows unread new data
// - lost flag marks overwritten unread data
// - flag enables decide pending after rx/tx
// - answer enable lets remote frames raise request
// - lengths above eight behave as eight
// - lowest pending object is reported as source
// - 32 objects reached only through interface registers
//
// The APB slave port and the register offsets were left to the implementer.
`default_nettype none
module cmf_message_filter
  import cmf_pkg::*;
#(
  parameter int N_OBJ = OBJ_COUNT
)(
  // clock and reset
  input  wire  logic                clk_sys,
  input  wire  logic                rst,
  // apb slave
  input  wire  logic [7:0]          paddr,
  input  wire  logic                psel,
  input  wire  logic                penable,
  input  wire  logic                pwrite,
  input  wire  logic [31:0]         pwdata,
  output logic       [31:0]         prdata,
  output logic                      pready,
  output logic                      pslverr,
  // received frame from protocol engine
  input  wire  logic                rx_frame_valid,
  input  wire  logic [ID_W-1:0]     rx_id,
  input  wire  logic                rx_ext,
  input  wire  logic                rx_remote,
  input  wire  logic [DLC_W-1:0]    rx_dlc,
  input  wire  logic [DATA_W-1:0]   rx_data,
  // frame to protocol engine
  output logic                      tx_start,
  output logic [4:0]                tx_index,
  output logic [ID_W-1:0]           tx_id,
  output logic                      tx_ext,
  output logic                      tx_remote,
  output logic [DLC_W-1:0]          tx_dlc,
  output logic [DATA_W-1:0]         tx_data,
  input  wire  logic                tx_complete,
  // status
  output logic                      config_hold,
  output logic                      send_success,
  output logic [5:0]                pending_source_index
);

  // message store: one entry per object, software only via staging
  logic [N_OBJ-1:0] object_valid, transfer_way_flag, extended_id_flag;
  logic [N_OBJ-1:0] mask_enable, ext_id_mask, way_mask, buffer_end_flag;
  logic [N_OBJ-1:0] fresh_data_flag, overrun_lost_flag, rx_flag_enable;
  logic [N_OBJ-1:0] tx_flag_enable, pending_flag, remote_answer_enable;
  logic [N_OBJ-1:0] send_request;
  logic [ID_W-1:0]   object_identifier [N_OBJ];
  logic [ID_W-1:0]   id_mask_bits      [N_OBJ];
  logic [DLC_W-1:0]  length_code       [N_OBJ];
  logic [DATA_W-1:0] object_data       [N_OBJ];

  // staging registers
  logic [4:0]        cmd_obj;
  logic [31:0]       stage_cfg;
  logic [ID_W-1:0]   stage_id;
  logic [ID_W-1:0]   stage_mask;
  logic [DATA_W-1:0] stage_data;

  cmf_tx_state_t tx_state;

  // bus decode
  logic apb_wr, apb_setup, cmd_go, cpu_store, cpu_load;
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;
  assign cmd_go    = apb_wr && (paddr == REG_COMMAND);
  assign cpu_store = cmd_go && pwdata[CMD_WRITE_BIT];
  assign cpu_load  = cmd_go && !pwdata[CMD_WRITE_BIT];

  // acceptance filter, one comparator per object
  logic [N_OBJ-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < N_OBJ; g++)
    begin : g_filter
      logic [ID_W-1:0] care, cmp;
      logic            ext_ok, way_ok, id_ok, fifo_full;
      assign care   = mask_enable[g] ? id_mask_bits[g] : '1;
      assign cmp    = rx_ext ? care : {care[ID_W-1:STD_LSB], {STD_LSB{1'b0}}};
      assign id_ok  = ((object_identifier[g] ^ rx_id) & cmp) == '0;
      assign ext_ok = (mask_enable[g] && !ext_id_mask[g]) ||
                      (extended_id_flag[g] == rx_ext);
      assign way_ok = (mask_enable[g] && !way_mask[g]) ||
                      (transfer_way_flag[g] == rx_remote);
      // a full non-tail fifo member above object 0 passes the frame on to the next one
      assign fifo_full = (g >= 1) && !buffer_end_flag[g] && fresh_data_flag[g];
      assign hit[g] = object_valid[g] && id_ok && ext_ok && way_ok && !fifo_full;
    end
  endgenerate

  // lowest matching object wins
  logic       rx_any;
  logic [4:0] rx_sel;
  always_comb
  begin
    rx_any = 1'b0;
    rx_sel = 5'h00;
    for (int i = N_OBJ - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        rx_any = 1'b1;
        rx_sel = 5'(i);
      end
    end
  end

  // lowest valid object with a send request
  logic       tx_any;
  logic [4:0] tx_pick;
  logic       pend_any;
  logic [4:0] pend_pick;
  always_comb
  begin
    tx_any    = 1'b0;
    tx_pick   = 5'h00;
    pend_any  = 1'b0;
    pend_pick = 5'h00;
    for (int i = N_OBJ - 1; i >= 0; i--)
    begin
      if (object_valid[i] && send_request[i])
      begin
        tx_any  = 1'b1;
        tx_pick = 5'(i);
      end
      if (pending_flag[i])
      begin
        pend_any  = 1'b1;
        pend_pick = 5'(i);
      end
    end
  end

  logic rx_take, tx_fin;
  assign rx_take = rx_frame_valid && rx_any && !config_hold;
  assign tx_fin  = (tx_state == CMF_TX_SEND) && tx_complete;

  // clamp of the stored length for readback
  function automatic logic [3:0] cmf_len(input logic [3:0] code);
    cmf_len = (code > MAX_LEN) ? MAX_LEN : code;
  endfunction

  // object store updates; cpu first, hardware events after so a set wins
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      object_valid         <= '0;
      transfer_way_flag    <= '0;
      extended_id_flag     <= '0;
      mask_enable          <= '0;
      ext_id_mask          <= '0;
      way_mask             <= '1;
      buffer_end_flag      <= '1;
      fresh_data_flag      <= '0;
      overrun_lost_flag    <= '0;
      rx_flag_enable       <= '0;
      tx_flag_enable       <= '0;
      pending_flag         <= '0;
      remote_answer_enable <= '0;
      send_request         <= '0;
    end
    else
    begin
      for (int i = 0; i < N_OBJ; i++)
      begin
        if (cpu_store && cmd_obj == 5'(i))
        begin
          object_valid[i]         <= stage_cfg[CF_VALID];
          transfer_way_flag[i]    <= stage_cfg[CF_WAY];
          extended_id_flag[i]     <= stage_cfg[CF_EXT];
          mask_enable[i]          <= stage_cfg[CF_MASK_ENABLE];
          ext_id_mask[i]          <= stage_cfg[CF_XMASK];
          way_mask[i]             <= stage_cfg[CF_WMASK];
          buffer_end_flag[i]      <= stage_cfg[CF_BEND];
          fresh_data_flag[i]      <= stage_cfg[CF_FRESH];
          overrun_lost_flag[i]    <= stage_cfg[CF_LOST];
          rx_flag_enable[i]       <= stage_cfg[CF_RX_FLAG_ENABLE];
          tx_flag_enable[i]       <= stage_cfg[CF_TX_FLAG_ENABLE];
          pending_flag[i]         <= stage_cfg[CF_PEND];
          remote_answer_enable[i] <= stage_cfg[CF_RAE];
          send_request[i]         <= stage_cfg[CF_TXREQ];
          object_identifier[i]    <= stage_id;
          id_mask_bits[i]         <= stage_mask;
          length_code[i]          <= stage_cfg[CF_DLC_LSB +: DLC_W];
          object_data[i]          <= stage_data;
        end
        // accepted frame
        if (rx_take && rx_sel == 5'(i))
        begin
          if (!rx_remote || !transfer_way_flag[i])
          begin
            // data frame into any object, or remote into a receive object
            extended_id_flag[i] <= rx_ext;
            transfer_way_flag[i] <= rx_remote;
            length_code[i]      <= rx_dlc;
            object_data[i]      <= rx_data;
            if (rx_ext)
              object_identifier[i] <= rx_id;
            else
              object_identifier[i][ID_W-1:STD_LSB] <= rx_id[ID_W-1:STD_LSB];
            if (fresh_data_flag[i] && !transfer_way_flag[i])
              overrun_lost_flag[i] <= 1'b1;
            fresh_data_flag[i] <= 1'b1;
            if (rx_flag_enable[i])
              pending_flag[i] <= 1'b1;
          end
          else if (remote_answer_enable[i])
          begin
            if (!send_request[i])
              send_request[i] <= 1'b1;
          end
          else if (mask_enable[i])
          begin
            // treated like data: header refreshed, payload kept
            send_request[i]     <= 1'b0;
            extended_id_flag[i] <= rx_ext;
            transfer_way_flag[i] <= rx_remote;
            length_code[i]      <= rx_dlc;
            if (rx_ext)
              object_identifier[i] <= rx_id;
            else
              object_identifier[i][ID_W-1:STD_LSB] <= rx_id[ID_W-1:STD_LSB];
            fresh_data_flag[i] <= 1'b1;
            if (rx_flag_enable[i])
              pending_flag[i] <= 1'b1;
          end
          // otherwise the remote frame is dropped, request untouched
        end
        // finished transmission
        if (tx_fin && tx_index == 5'(i))
        begin
          // an object invalidated mid-send keeps its request for software
          if (object_valid[i])
            send_request[i] <= 1'b0;
          if (tx_flag_enable[i])
            pending_flag[i] <= 1'b1;
        end
      end
    end
  end

  // transmit sequencer; held off while configuration hold is set
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tx_state  <= CMF_TX_IDLE;
      tx_start  <= 1'b0;
      tx_index  <= 5'h00;
      tx_id     <= '0;
      tx_ext    <= 1'b0;
      tx_remote <= 1'b0;
      tx_dlc    <= '0;
      tx_data   <= '0;
    end
    else
    begin
      tx_start <= 1'b0;
      case (tx_state)
        CMF_TX_IDLE:
        begin
          if (tx_any && !config_hold)
          begin
            tx_state  <= CMF_TX_SEND;
            tx_start  <= 1'b1;
            tx_index  <= tx_pick;
            tx_id     <= object_identifier[tx_pick];
            tx_ext    <= extended_id_flag[tx_pick];
            tx_remote <= !transfer_way_flag[tx_pick];
            tx_dlc    <= cmf_len(length_code[tx_pick]);
            tx_data   <= object_data[tx_pick];
          end
        end
        CMF_TX_SEND:
        begin
          if (tx_complete)
            tx_state <= CMF_TX_CLOSE;
        end
        // one cycle so the cleared request settles before reselection
        CMF_TX_CLOSE:
          tx_state <= CMF_TX_IDLE;
        default:
          tx_state <= CMF_TX_IDLE;
      endcase
    end
  end

  // control register and send success, set wins over clear
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      config_hold  <= HOLD_RESET;
      send_success <= 1'b0;
    end
    else
    begin
      if (apb_wr && paddr == REG_CONTROL)
      begin
        config_hold <= pwdata[CT_HOLD];
        if (pwdata[CT_SENT])
          send_success <= 1'b0;
      end
      if (tx_fin)
        send_success <= 1'b1;
    end
  end

  // pending source: message number is index plus one, zero for none
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pending_source_index <= 6'h00;
    else
      pending_source_index <= pend_any ? 6'({1'b0, pend_pick} + 6'h01) : 6'h00;
  end

  // staging registers: written by apb or loaded from an object
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cmd_obj    <= 5'h00;
      stage_cfg  <= 32'h0000_0000;
      stage_id   <= '0;
      stage_mask <= '0;
      stage_data <= '0;
    end
    else if (cpu_load)
    begin
      cmd_obj    <= pwdata[4:0];
      stage_cfg  <= {8'h00, cmf_len(length_code[pwdata[4:0]]), length_code[pwdata[4:0]],
                     2'b00, send_request[pwdata[4:0]], remote_answer_enable[pwdata[4:0]],
                     pending_flag[pwdata[4:0]], tx_flag_enable[pwdata[4:0]],
                     rx_flag_enable[pwdata[4:0]], overrun_lost_flag[pwdata[4:0]],
                     fresh_data_flag[pwdata[4:0]], buffer_end_flag[pwdata[4:0]],
                     way_mask[pwdata[4:0]], ext_id_mask[pwdata[4:0]],
                     mask_enable[pwdata[4:0]], extended_id_flag[pwdata[4:0]],
                     transfer_way_flag[pwdata[4:0]], object_valid[pwdata[4:0]]};
      stage_id   <= object_identifier[pwdata[4:0]];
      stage_mask <= id_mask_bits[pwdata[4:0]];
      stage_data <= object_data[pwdata[4:0]];
    end
    else if (apb_wr)
    begin
      case (paddr)
        REG_COMMAND: cmd_obj              <= pwdata[4:0];
        REG_CONFIG:  stage_cfg            <= pwdata;
        REG_IDENT:   stage_id             <= pwdata[ID_W-1:0];
        REG_MASK:    stage_mask           <= pwdata[ID_W-1:0];
        REG_DATA_A:  stage_data[31:0]     <= pwdata;
        REG_DATA_B:  stage_data[63:32]    <= pwdata;
        default:     cmd_obj              <= cmd_obj;
      endcase
    end
  end

  // apb answer: one access cycle, data registered in setup
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_setup)
      begin
        case (paddr)
          REG_COMMAND: prdata <= {27'h0000000, cmd_obj};
          REG_CONFIG:  prdata <= stage_cfg;
          REG_IDENT:   prdata <= {3'h0, stage_id};
          REG_MASK:    prdata <= {3'h0, stage_mask};
          REG_DATA_A:  prdata <= stage_data[31:0];
          REG_DATA_B:  prdata <= stage_data[63:32];
          REG_CONTROL: prdata <= {30'h00000000, send_success, config_hold};
          REG_PENDING: prdata <= {26'h0000000, pending_source_index};
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/cmf_pkg.sv
`default_nettype none
package cmf_pkg;
  // message store shape
  localparam int OBJ_COUNT = 32;
  localparam int ID_W      = 29;
  localparam int STD_LSB   = 18;   // standard ids live in bits 28:18
  localparam int DLC_W     = 4;
  localparam int DATA_W    = 64;

  // apb word offsets, byte addressed
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_CONFIG  = 8'h04;
  localparam logic [7:0] REG_IDENT   = 8'h08;
  localparam logic [7:0] REG_MASK    = 8'h0c;
  localparam logic [7:0] REG_DATA_A  = 8'h10;
  localparam logic [7:0] REG_DATA_B  = 8'h14;
  localparam logic [7:0] REG_CONTROL = 8'h18;
  localparam logic [7:0] REG_PENDING = 8'h1c;

  // command register fields
  localparam int CMD_WRITE_BIT = 8;

  // config staging word fields
  localparam int CF_VALID   = 0;
  localparam int CF_WAY     = 1;
  localparam int CF_EXT     = 2;
  localparam int CF_MASK_ENABLE   = 3;
  localparam int CF_XMASK   = 4;
  localparam int CF_WMASK   = 5;
  localparam int CF_BEND    = 6;
  localparam int CF_FRESH   = 7;
  localparam int CF_LOST    = 8;
  localparam int CF_RX_FLAG_ENABLE    = 9;
  localparam int CF_TX_FLAG_ENABLE    = 10;
  localparam int CF_PEND    = 11;
  localparam int CF_RAE     = 12;
  localparam int CF_TXREQ   = 13;
  localparam int CF_DLC_LSB = 16;
  localparam int CF_LEN_LSB = 20;

  // control register fields, hold reset value and length limit
  localparam int          CT_HOLD    = 0;
  localparam int          CT_SENT    = 1;
  localparam logic        HOLD_RESET = 1'b1;
  localparam logic [3:0]  MAX_LEN    = 4'h8;

  // transmit sequencer, gray coded except the close to idle step, which flips both bits
  typedef enum logic [1:0] {
    CMF_TX_IDLE  = 2'b00,
    CMF_TX_SEND  = 2'b01,
    CMF_TX_CLOSE = 2'b11
  } cmf_tx_state_t;
endpackage
`default_nettype wire

// File: verification/cmf_message_filter_checker.sv
`default_nettype none
module cmf_message_filter_checker
  import cmf_pkg::*;
#(
  parameter int N_OBJ = OBJ_COUNT
)(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst,
  // apb
  input wire logic [7:0]        paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // engine side
  input wire logic              tx_start,
  input wire logic [ID_W-1:0]   tx_id,
  input wire logic [DLC_W-1:0]  tx_dlc,
  input wire logic              tx_complete,
  // status
  input wire logic              config_hold,
  input wire logic              send_success,
  input wire logic [5:0]        pending_source_index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // completions only count inside a started transmission
  logic in_send, hold_req;
  wire logic ctl_wr = psel && penable && pwrite && pready && paddr == REG_CONTROL;
  always_ff @(posedge clk_sys)
  begin
    if (rst || tx_complete)
      in_send <= 1'b0;
    else if (tx_start)
      in_send <= 1'b1;
  end
  // hold value the cpu asked for
  always_ff @(posedge clk_sys)
  begin
    hold_req <= pwdata[CT_HOLD];
  end

  property p_setup_ready; psel && !penable |=> pready; endproperty
  a_setup_ready: assert property (p_setup_ready) else $error("no ready after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready longer than one cycle");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
  property p_unmapped; psel && !penable && paddr > REG_PENDING |=> pslverr && pready; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped address not refused");
  property p_hold_write; ctl_wr |=> config_hold == hold_req; endproperty
  a_hold_write: assert property (p_hold_write) else $error("hold bit not taken");
  property p_tx_spacing; tx_start |=> !tx_start [*2]; endproperty
  a_tx_spacing: assert property (p_tx_spacing) else $error("starts too close");
  property p_tx_stable; !tx_start |-> $stable(tx_id) && $stable(tx_dlc); endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("frame changed between starts");
  property p_tx_len; tx_start |-> tx_dlc <= MAX_LEN; endproperty
  a_tx_len: assert property (p_tx_len) else $error("length above eight");
  property p_success; in_send && tx_complete |=> send_success; endproperty
  a_success: assert property (p_success) else $error("success not set");
  property p_sticky; send_success && !(ctl_wr && pwdata[CT_SENT]) |=> send_success; endproperty
  a_sticky: assert property (p_sticky) else $error("success lost");
  property p_src_range; pending_source_index <= N_OBJ; endproperty
  a_src_range: assert property (p_src_range) else $error("source index out of range");

  c_tx_done: cover property (in_send && tx_complete);
  c_refused: cover property (pslverr);
  c_pending: cover property (pending_source_index != 6'h0);
endmodule

bind cmf_message_filter cmf_message_filter_checker #(.N_OBJ(N_OBJ)) chk_i (
  .clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_start(tx_start),
  .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_complete(tx_complete), .config_hold(config_hold),
  .send_success(send_success), .pending_source_index(pending_source_index));
`default_nettype wire

// File: verification/cmf_bus_node.sv
`default_nettype none
module cmf_bus_node
  import cmf_pkg::*;
(
  // clock
  input  wire logic              clk_sys,
  // frames heard on the bus
  output logic                   rx_frame_valid,
  output logic [ID_W-1:0]        rx_id,
  output logic                   rx_ext,
  output logic                   rx_remote,
  output logic [DLC_W-1:0]       rx_dlc,
  output logic [DATA_W-1:0]      rx_data,
  // frames sent by the block
  input  wire logic              tx_start,
  output logic                   tx_complete
);
  timeunit 1ns;
  timeprecision 1ps;
  int slow_cycles = 2, cnt = 0;

  // quiet bus at time zero
  initial
  begin
    rx_frame_valid = 1'b0;
    {rx_id, rx_ext, rx_remote, rx_dlc, rx_data} = '0;
    tx_complete = 1'b0;
  end

  // one frame, then stale fields inverted so nothing leans on them
  task automatic send_frame(input logic [ID_W-1:0] id, input logic e, r, input logic [3:0] d, input logic [63:0] x);
    @(posedge clk_sys);
    rx_frame_valid <= 1'b1;
    {rx_id, rx_ext, rx_remote, rx_dlc, rx_data} <= {id, e, r, d, x};
    @(posedge clk_sys);
    rx_frame_valid <= 1'b0;
    {rx_id, rx_ext, rx_remote, rx_dlc, rx_data} <= ~{id, e, r, d, x};
  endtask

  // acknowledge each start after a chosen delay
  always @(posedge clk_sys)
  begin
    tx_complete <= 1'b0;
    if (tx_start === 1'b1)
      cnt <= slow_cycles;
    else if (cnt == 1)
      tx_complete <= 1'b1;
    if (cnt > 0 && tx_start !== 1'b1)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// File: verification/testbench.sv
`default_nettype none
module testbench
  import cmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] V = 32'h1 << CF_VALID, W = 32'h1 << CF_WAY, X = 32'h1 << CF_EXT;
  localparam logic [31:0] UM = 32'h1 << CF_MASK_ENABLE, XM = 32'h1 << CF_XMASK, RX = 32'h1 << CF_RX_FLAG_ENABLE;
  localparam logic [31:0] TX = 32'h1 << CF_TX_FLAG_ENABLE, RA = 32'h1 << CF_RAE, TQ = 32'h1 << CF_TXREQ, PD = 32'h1 << CF_PEND;
  // valid, direction always compared, standalone object
  localparam logic [31:0] B = V | (32'h1 << CF_WMASK) | (32'h1 << CF_BEND);
  typedef struct packed {
    logic [ID_W-1:0] id;
    logic e, r;
    logic [3:0] dlc;
    logic [4:0] obj;
    logic f, p;
    logic [7:0] ld;
    logic [31:0] da;
  } cmf_row_t;
  // frame, object to inspect, expected fresh, pending, lengths, data
  cmf_row_t rows [6] = '{
    '{29'h1abcdef5, 1'b0, 1'b0, 4'h2, 5'd2, 1'b0, 1'b0, 8'h22, 32'h0},
    '{29'h05540000, 1'b0, 1'b1, 4'h0, 5'd8, 1'b0, 1'b0, 8'h00, 32'h0},
    '{29'h048c0000, 1'b0, 1'b0, 4'h4, 5'd1, 1'b1, 1'b1, 8'h44, 32'hd00d0002},
    '{29'h1abcdef5, 1'b1, 1'b0, 4'h8, 5'd2, 1'b1, 1'b0, 8'h88, 32'hd00d0003},
    '{29'h03300000, 1'b0, 1'b1, 4'h3, 5'd9, 1'b1, 1'b0, 8'h33, 32'hcafe0009},
    '{29'h0c840000, 1'b0, 1'b0, 4'hc, 5'd10, 1'b1, 1'b1, 8'h8c, 32'hd00d0005}};
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic [7:0]        paddr = 8'h0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0, prdata, rd_v;
  logic              pready, pslverr, er_v, rx_frame_valid, rx_ext, rx_remote;
  logic              tx_start, tx_ext, tx_remote, tx_complete, config_hold, send_success, s_rmt, s_ext;
  logic [ID_W-1:0]   rx_id, tx_id, s_id;
  logic [DLC_W-1:0]  rx_dlc, tx_dlc, s_dlc;
  logic [DATA_W-1:0] rx_data, tx_data;
  logic [4:0]        tx_index, s_idx;
  logic [5:0]        pending_source_index;
  int                mismatches = 0, checks_done = 0, starts = 0;

  always #5 clk_sys = ~clk_sys;

  cmf_message_filter cmf_message_filter_i (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_valid(rx_frame_valid), .rx_id(rx_id), .rx_ext(rx_ext), .rx_remote(rx_remote), .rx_dlc(rx_dlc),
    .rx_data(rx_data), .tx_start(tx_start), .tx_index(tx_index), .tx_id(tx_id), .tx_ext(tx_ext),
    .tx_remote(tx_remote), .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_complete(tx_complete),
    .config_hold(config_hold), .send_success(send_success), .pending_source_index(pending_source_index));
  cmf_bus_node cmf_bus_node_i (.clk_sys(clk_sys), .rx_frame_valid(rx_frame_valid), .rx_id(rx_id),
    .rx_ext(rx_ext), .rx_remote(rx_remote), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_start(tx_start),
    .tx_complete(tx_complete));

  // remember what each start announced
  always @(posedge clk_sys)
  begin
    if (tx_start === 1'b1)
    begin
      starts <= starts + 1;
      {s_idx, s_rmt, s_ext, s_dlc, s_id} <= {tx_index, tx_remote, tx_ext, tx_dlc, tx_id};
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e, input string s);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, s, g, e);
    end
  endtask

  // one transfer, then an idle edge so strobes never double up
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    {pwrite, paddr, pwdata} <= {w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    for (n = 0; pready !== 1'b1; n++)
      @(posedge clk_sys);
    chk(32'(n), 32'h0, "apb answer");
    {rd_v, er_v} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk_sys);
  endtask

  // load, edit staging, store back
  task automatic obj_wr(input logic [4:0] o, input logic [31:0] c, id, m, da);
    apb(1'b1, REG_COMMAND, {27'h0, o});
    apb(1'b1, REG_CONFIG, c);
    apb(1'b1, REG_IDENT, id);
    apb(1'b1, REG_MASK, m);
    apb(1'b1, REG_DATA_A, da);
    apb(1'b1, REG_COMMAND, {27'h0, o} | (32'h1 << CMD_WRITE_BIT));
  endtask

  task automatic cfg_rd(input logic [4:0] o);
    apb(1'b1, REG_COMMAND, {27'h0, o});
    apb(1'b0, REG_CONFIG, 32'h0);
  endtask

  // hang guard, well past the expected run of some 400 cycles
  initial
  begin
    #100us;
    chk(32'h0, 32'h1, "watchdog");
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] m;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk({24'h0, config_hold, send_success, pending_source_index}, 32'h80, "reset outputs");
    apb(1'b0, REG_CONTROL, 32'h0);
    chk(rd_v & 32'h3, 32'h1, "control reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er_v}, 32'h1, "unmapped");
    cfg_rd(5'd0);
    chk(rd_v & 32'h3fff, B & ~V, "object reset");
    // configured under hold, unused ones left invalid
    obj_wr(5'd0, B & ~V, 32'h048c0000, 32'h0, 32'h0);
    obj_wr(5'd1, B | RX, 32'h048c0000, 32'h0, 32'h0);
    obj_wr(5'd2, B | X | UM | XM, 32'h1abcdef0, 32'h1ffffff0, 32'h0);
    obj_wr(5'd6, B | RX, 32'h048c0000, 32'h0, 32'h0);
    obj_wr(5'd7, B | W | RA | TX, 32'h02a80000, 32'h0, 32'h0);
    obj_wr(5'd8, B | W, 32'h05540000, 32'h0, 32'h0);
    obj_wr(5'd9, B | W | UM, 32'h03300000, 32'h1ffc0000, 32'hcafe0009);
    obj_wr(5'd10, B | RX, 32'h0c840000, 32'h0, 32'h0);
    apb(1'b1, REG_CONTROL, 32'h0);
    foreach (rows[i])
    begin
      cmf_bus_node_i.send_frame(rows[i].id, rows[i].e, rows[i].r, rows[i].dlc, {32'h1, 32'hd00d0000 | 32'(i)});
      repeat (3) @(posedge clk_sys);
      cfg_rd(rows[i].obj);
      m = rows[i].f ? 32'hff0884 : 32'h80;
      chk(rd_v & m, ({8'h0, rows[i].ld, 16'h0} | {20'h0, rows[i].p, 3'h0, rows[i].f, 4'h0, rows[i].e, 2'h0}) & m,
          "object flags");
      if (rows[i].f)
      begin
        apb(1'b0, REG_IDENT, 32'h0);
        chk(rd_v, {3'h0, rows[i].id}, "identifier");
        apb(1'b0, REG_DATA_A, 32'h0);
        chk(rd_v, rows[i].da, "data");
      end
    end
    chk({26'h0, pending_source_index}, 32'h2, "source index");
    // remote frame raises a request on the answering object
    cmf_bus_node_i.send_frame(29'h02a80000, 1'b0, 1'b1, 4'h0, 64'h0);
    for (int n = 0; n < 100 && starts < 1; n++) @(posedge clk_sys);
    chk({s_idx, s_rmt, s_ext, s_dlc, 21'h0}, {5'd7, 1'b0, 1'b0, 4'h0, 21'h0}, "answer frame");
    chk({3'h0, s_id}, {3'h0, 29'h02a80000}, "answer identifier");
    for (int n = 0; n < 100 && send_success !== 1'b1; n++) @(posedge clk_sys);
    chk({31'h0, send_success}, 32'h1, "success");
    cfg_rd(5'd7);
    chk(rd_v & (TQ | PD), PD, "after send");
    apb(1'b1, REG_CONTROL, 32'h1 << CT_SENT);
    chk({31'h0, send_success}, 32'h0, "success cleared");
    // receive object asks remotely, then is invalidated mid-send
    cmf_bus_node_i.slow_cycles = 40;
    obj_wr(5'd11, B | TQ, 32'h0, 32'h0, 32'h0);
    for (int n = 0; n < 100 && starts < 2; n++) @(posedge clk_sys);
    chk({27'h0, s_idx, s_rmt}, {27'h0, 5'd11, 1'b1}, "remote request");
    obj_wr(5'd11, (B & ~V) | TQ, 32'h0, 32'h0, 32'h0);
    for (int n = 0; n < 100 && send_success !== 1'b1; n++) @(posedge clk_sys);
    chk({31'h0, send_success}, 32'h1, "success after invalidate");
    cfg_rd(5'd11);
    chk(rd_v & (V | TQ), TQ, "request kept");
    tally_and_finish();
  end
endmodule
`default_nettype wire
